// >>> hw/drf_rename_fwd.sv
// Rename, operand forwarding, result forwarding and memory bypass for a paired core.
// Assumes dispatch, execute and write-back logic on the same clock drive every input.
`timescale 1ns/1ps
`default_nettype none
module drf_rename_fwd
(
    input wire logic clk,
    input wire logic resetn,
    input wire logic disp_valid,
    output logic disp_ready,
    input wire logic pipe_adv,
    input wire drf_pkg::drf_lreg_t x_src_a,
    input wire drf_pkg::drf_lreg_t x_src_b,
    input wire logic x_dst_we,
    input wire drf_pkg::drf_lreg_t x_dst,
    input wire logic x_mem_rd,
    input wire logic x_mem_wr,
    input wire logic x_is_move,
    input wire drf_pkg::drf_word_t x_mem_addr,
    input wire logic y_valid,
    input wire drf_pkg::drf_lreg_t y_src_a,
    input wire drf_pkg::drf_lreg_t y_src_b,
    input wire logic y_dst_we,
    input wire drf_pkg::drf_lreg_t y_dst,
    input wire logic y_mem_rd,
    input wire drf_pkg::drf_word_t y_mem_addr,
    input wire drf_pkg::drf_word_t mem_data,
    input wire logic x_result_valid,
    input wire drf_pkg::drf_word_t x_result,
    output logic ex_valid,
    output drf_pkg::drf_preg_t x_pdst,
    output drf_pkg::drf_preg_t y_pdst,
    output drf_pkg::drf_preg_t x_pold,
    output drf_pkg::drf_preg_t y_pold,
    output drf_pkg::drf_word_t x_op_a,
    output drf_pkg::drf_word_t x_op_b,
    output drf_pkg::drf_word_t x_mem_op,
    output drf_pkg::drf_word_t y_op_a,
    output drf_pkg::drf_word_t y_op_b,
    output drf_pkg::drf_word_t y_mem_op,
    output logic y_hold,
    input wire logic x_store_issue,
    output logic y_store_allow,
    input wire logic wb_x_we,
    input wire drf_pkg::drf_preg_t wb_x_tag,
    input wire drf_pkg::drf_word_t wb_x_data,
    input wire logic wb_y_we,
    input wire drf_pkg::drf_preg_t wb_y_tag,
    input wire drf_pkg::drf_word_t wb_y_data,
    input wire logic rel_x_valid,
    input wire drf_pkg::drf_preg_t rel_x_tag,
    input wire logic rel_y_valid,
    input wire drf_pkg::drf_preg_t rel_y_tag
);
    function automatic drf_pkg::drf_preg_t first_free(input drf_pkg::drf_pmask_t m);
        drf_pkg::drf_preg_t t;
        t = drf_pkg::PREG_ZERO;
        for (int i = drf_pkg::NPHYS - 1; i >= 0; i--)
            if (m[i])
                t = drf_pkg::drf_preg_t'(i);
        return t;
    endfunction

    function automatic drf_pkg::drf_cnt_t count_free(input drf_pkg::drf_pmask_t m);
        drf_pkg::drf_cnt_t c;
        c = '0;
        for (int i = 0; i < drf_pkg::NPHYS; i++)
            c = c + drf_pkg::drf_cnt_t'(m[i]);
        return c;
    endfunction

    function automatic drf_pkg::drf_sel_t ysel_f(input drf_pkg::drf_lreg_t src,
        input logic hit, input drf_pkg::drf_lreg_t dst, input logic load);
        if (hit && src == dst)
            return load ? drf_pkg::SEL_MEM : drf_pkg::SEL_XRES;
        return drf_pkg::SEL_RF;
    endfunction

    function automatic drf_pkg::drf_pmask_t onehot(input logic en, input drf_pkg::drf_preg_t t);
        return en ? (drf_pkg::PMASK_ONE << t) : '0;
    endfunction

    drf_rf_if rf ();

    drf_prf u_prf
    (
        .clk(clk),
        .resetn(resetn),
        .rf(rf)
    );

    drf_pkg::drf_preg_t map_reg [drf_pkg::NLOG];
    drf_pkg::drf_preg_t map_next [drf_pkg::NLOG];
    drf_pkg::drf_pmask_t free_reg;
    drf_pkg::drf_stage_t a2_reg;
    drf_pkg::drf_stage_t ex_reg;
    drf_pkg::drf_word_t x_op_a_reg, x_op_b_reg, y_op_a_reg, y_op_b_reg, mem_op_reg;
    logic xst_pend_reg;

    // One pair takes at most two tags, so the check counts only what it needs.
    wire drf_pkg::drf_cnt_t free_cnt = count_free(free_reg);
    wire drf_pkg::drf_cnt_t need = drf_pkg::drf_cnt_t'(x_dst_we)
        + drf_pkg::drf_cnt_t'(y_valid & y_dst_we);
    wire logic acc = disp_valid && disp_ready;
    wire logic x_alloc = acc && x_dst_we;
    wire logic y_alloc = acc && y_valid && y_dst_we;
    wire drf_pkg::drf_preg_t x_new = first_free(free_reg);
    wire drf_pkg::drf_preg_t y_new = first_free(free_reg & ~onehot(x_alloc, x_new));
    wire logic x_load = x_is_move && x_mem_rd;
    wire logic x_hit = x_dst_we;
    wire logic byp_hit = x_mem_wr && y_mem_rd && x_mem_addr == y_mem_addr;
    wire drf_pkg::drf_pmask_t alloc_mask = onehot(x_alloc, x_new) | onehot(y_alloc, y_new);
    wire drf_pkg::drf_pmask_t rel_mask = onehot(rel_x_valid, rel_x_tag)
        | onehot(rel_y_valid, rel_y_tag);
    wire logic same_dst = x_alloc && y_dst == x_dst;
    wire logic a2_go = pipe_adv && a2_reg.valid;

    assign disp_ready = pipe_adv && free_cnt >= need;

    // Primary operands always read the mapping that stood before this pair.
    assign rf.re = pipe_adv;
    assign rf.raddr[0] = map_reg[x_src_a];
    assign rf.raddr[1] = map_reg[x_src_b];
    assign rf.raddr[2] = (x_alloc && y_src_a == x_dst) ? x_new : map_reg[y_src_a];
    assign rf.raddr[3] = (x_alloc && y_src_b == x_dst) ? x_new : map_reg[y_src_b];
    assign rf.we[0] = wb_x_we;
    assign rf.waddr[0] = wb_x_tag;
    assign rf.wdata[0] = wb_x_data;
    assign rf.we[1] = wb_y_we;
    assign rf.waddr[1] = wb_y_tag;
    assign rf.wdata[1] = wb_y_data;

    // The secondary writer is applied last so a shared destination ends on its tag.
    always_comb
    begin
        map_next = map_reg;
        if (x_alloc)
            map_next[x_dst] = x_new;
        if (y_alloc)
            map_next[y_dst] = y_new;
    end

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            for (int i = 0; i < drf_pkg::NLOG; i++)
                map_reg[i] <= drf_pkg::drf_preg_t'(i);
            free_reg <= drf_pkg::FREE_RST;
        end
        else
        begin
            map_reg <= map_next;
            free_reg <= (free_reg & ~alloc_mask) | rel_mask;
        end
    end

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
            a2_reg <= drf_pkg::STAGE_RST;
        else if (pipe_adv)
        begin
            a2_reg.valid <= acc;
            a2_reg.x_mwr <= x_mem_wr;
            a2_reg.ysel_a <= ysel_f(y_src_a, x_hit, x_dst, x_load);
            a2_reg.ysel_b <= ysel_f(y_src_b, x_hit, x_dst, x_load);
            a2_reg.ymsel <= byp_hit ? drf_pkg::SEL_XRES : drf_pkg::SEL_MEM;
            a2_reg.x_pdst <= x_new;
            a2_reg.y_pdst <= y_new;
            a2_reg.x_pold <= map_reg[x_dst];
            a2_reg.y_pold <= same_dst ? x_new : map_reg[y_dst];
        end
    end

    // Operands are latched at the end of the cache access stage into one set of flops.
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            ex_reg <= drf_pkg::STAGE_RST;
            x_op_a_reg <= drf_pkg::WORD_ZERO;
            x_op_b_reg <= drf_pkg::WORD_ZERO;
            y_op_a_reg <= drf_pkg::WORD_ZERO;
            y_op_b_reg <= drf_pkg::WORD_ZERO;
            mem_op_reg <= drf_pkg::WORD_ZERO;
        end
        else if (pipe_adv)
        begin
            ex_reg <= a2_reg;
            x_op_a_reg <= rf.rdata[0];
            x_op_b_reg <= rf.rdata[1];
            y_op_a_reg <= (a2_reg.ysel_a == drf_pkg::SEL_MEM) ? mem_data : rf.rdata[2];
            y_op_b_reg <= (a2_reg.ysel_b == drf_pkg::SEL_MEM) ? mem_data : rf.rdata[3];
            mem_op_reg <= mem_data;
        end
    end

    // The store-order flag is set by a newly entering store, which beats a clear.
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
            xst_pend_reg <= 1'b0;
        else
            xst_pend_reg <= (a2_go && a2_reg.x_mwr) || (xst_pend_reg && !x_store_issue);
    end

    wire logic ya_x = ex_reg.ysel_a == drf_pkg::SEL_XRES;
    wire logic yb_x = ex_reg.ysel_b == drf_pkg::SEL_XRES;
    wire logic ym_x = ex_reg.ymsel == drf_pkg::SEL_XRES;

    assign ex_valid = ex_reg.valid;
    assign x_pdst = ex_reg.x_pdst;
    assign y_pdst = ex_reg.y_pdst;
    assign x_pold = ex_reg.x_pold;
    assign y_pold = ex_reg.y_pold;
    assign x_op_a = x_op_a_reg;
    assign x_op_b = x_op_b_reg;
    assign x_mem_op = mem_op_reg;
    // Result forwarding is a same-cycle path from the primary adder, a deliberate timing cost.
    assign y_op_a = ya_x ? x_result : y_op_a_reg;
    assign y_op_b = yb_x ? x_result : y_op_b_reg;
    assign y_mem_op = ym_x ? x_result : mem_op_reg;
    assign y_hold = ex_reg.valid && (ya_x || yb_x || ym_x) && !x_result_valid;
    assign y_store_allow = ex_reg.valid && !xst_pend_reg;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);

    AST_STALL: assert property (disp_valid && free_cnt < need |-> !disp_ready)
        else $error("dispatch accepted without enough free tags");
    AST_FRESH: assert property (x_alloc |-> free_reg[x_new] ##1 !free_reg[$past(x_new)])
        else $error("primary destination tag was not free or stayed free");
    AST_WAW: assert property (y_alloc && same_dst |=>
        map_reg[$past(y_dst)] == a2_reg.y_pdst && a2_reg.x_pdst != a2_reg.y_pdst)
        else $error("shared destination not mapped to the secondary tag");
    AST_WAR: assert property (y_alloc && x_src_a == y_dst |-> rf.raddr[0] != y_new)
        else $error("primary reader saw the secondary new tag");
    AST_MEMBOTH: assert property (ex_reg.valid && !ym_x |-> y_mem_op == x_mem_op)
        else $error("memory operand differs between pipes");
    AST_OPFWD: assert property (a2_go && a2_reg.ysel_a == drf_pkg::SEL_MEM
        |=> y_op_a == $past(mem_data))
        else $error("load data not forwarded to secondary operand");
    AST_RESFWD: assert property (ex_reg.valid && ya_x && x_result_valid
        |-> y_op_a == x_result && !y_hold)
        else $error("primary result not forwarded to secondary move");
    AST_BYP: assert property (ex_reg.valid && ym_x && !x_result_valid |-> y_hold)
        else $error("bypassed secondary ran before primary result");
    AST_ORDER: assert property (a2_go && a2_reg.x_mwr |=> !y_store_allow)
        else $error("secondary store allowed ahead of primary store");
endmodule
`default_nettype wire

// >>> hw/drf_pkg.sv
// Shared constants and types for the dual-pipe rename and forwarding block.
// Assumes one core clock and one renamed pair per cycle at most.
package drf_pkg;
    localparam int NLOG = 8;
    localparam int NPHYS = 32;
    localparam int NRD = 4;
    localparam int NWR = 2;
    typedef logic [2:0] drf_lreg_t;
    typedef logic [4:0] drf_preg_t;
    typedef logic [31:0] drf_word_t;
    typedef logic [31:0] drf_pmask_t;
    typedef logic [5:0] drf_cnt_t;
    localparam drf_pmask_t FREE_RST = 32'hffffff00;
    localparam drf_pmask_t PMASK_ONE = 32'h00000001;
    localparam drf_word_t WORD_ZERO = 32'h00000000;
    localparam drf_preg_t PREG_ZERO = 5'h00;
    // Operand source for a secondary-pipe operand.
    typedef enum logic [2:0]
    {
        SEL_RF = 3'h1,
        SEL_MEM = 3'h2,
        SEL_XRES = 3'h4
    } drf_sel_t;
    typedef struct packed
    {
        logic valid;
        logic x_mwr;
        drf_sel_t ysel_a;
        drf_sel_t ysel_b;
        drf_sel_t ymsel;
        drf_preg_t x_pdst;
        drf_preg_t y_pdst;
        drf_preg_t x_pold;
        drf_preg_t y_pold;
    } drf_stage_t;
    localparam drf_stage_t STAGE_RST = '{1'b0, 1'b0, SEL_RF, SEL_RF, SEL_MEM,
        PREG_ZERO, PREG_ZERO, PREG_ZERO, PREG_ZERO};
endpackage

// >>> hw/drf_rf_if.sv
// Port bundle between the rename control and the physical register file.
// Assumes both ends share the core clock.
`timescale 1ns/1ps
`default_nettype none
interface drf_rf_if;
    logic re;
    drf_pkg::drf_preg_t raddr [drf_pkg::NRD];
    drf_pkg::drf_word_t rdata [drf_pkg::NRD];
    logic we [drf_pkg::NWR];
    drf_pkg::drf_preg_t waddr [drf_pkg::NWR];
    drf_pkg::drf_word_t wdata [drf_pkg::NWR];
    modport ctl (output re, output raddr, input rdata, output we, output waddr, output wdata);
    modport mem (input re, input raddr, output rdata, input we, input waddr, input wdata);
endinterface
`default_nettype wire

// >>> hw/drf_prf.sv
// Physical register pool: four registered read ports, two write ports.
// Assumes the control side never writes one tag from both ports at once.
`timescale 1ns/1ps
`default_nettype none
module drf_prf
(
    input wire logic clk,
    input wire logic resetn,
    drf_rf_if.mem rf
);
    drf_pkg::drf_word_t mem_reg [drf_pkg::NPHYS];

    always_ff @(posedge clk)
    begin
        for (int w = 0; w < drf_pkg::NWR; w++)
            if (rf.we[w])
                mem_reg[rf.waddr[w]] <= rf.wdata[w];
    end

    // Write-through keeps a same-cycle write-back visible to a reader of that tag.
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            for (int r = 0; r < drf_pkg::NRD; r++)
                rf.rdata[r] <= drf_pkg::WORD_ZERO;
        end
        else if (rf.re)
        begin
            for (int r = 0; r < drf_pkg::NRD; r++)
            begin
                rf.rdata[r] <= mem_reg[rf.raddr[r]];
                for (int w = 0; w < drf_pkg::NWR; w++)
                    if (rf.we[w] && rf.waddr[w] == rf.raddr[r])
                        rf.rdata[r] <= rf.wdata[w];
            end
        end
    end
endmodule
`default_nettype wire

// >>> dv/drf_exec_model.sv
// Behavioural execute stage that answers the primary result after a set latency.
// Assumes the bench sets the latency and value before each pair reaches EX.
`timescale 1ns/1ps
`default_nettype none
module drf_exec_model
(
    input wire logic clk,
    input wire logic resetn,
    input wire logic ex_valid,
    input wire logic y_hold,
    input wire logic [3:0] lat,
    input wire drf_pkg::drf_word_t res,
    output logic pipe_adv,
    output logic x_result_valid,
    output drf_pkg::drf_word_t x_result
);
    logic [3:0] wait_reg;
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
            wait_reg <= 4'h0;
        else if (ex_valid && !x_result_valid)
            wait_reg <= wait_reg + 4'h1;
        else
            wait_reg <= 4'h0;
    end
    assign x_result_valid = ex_valid && (wait_reg >= lat);
    // Before the result exists the bus carries its inverse, so a stale match cannot pass.
    assign x_result = x_result_valid ? res : ~res;
    // The whole pipe stalls while the secondary waits for the result.
    assign pipe_adv = !y_hold;
endmodule
`default_nettype wire

// >>> dv/test_dual_pipe_rename_forward.sv
// Self-checking bench for the dual-pipe rename and forwarding block.
// Assumes the execute model stands in for execute, while the bench drives dispatch and write-back itself.
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin fail_count++; \
    $display("Error %s expected %h seen %h", nm, (e), (g)); end end
module test_dual_pipe_rename_forward;
    logic clk = 1'b0;
    logic resetn = 1'b0;
    logic disp_valid, x_dst_we, x_mem_rd, x_mem_wr, x_is_move, y_valid, y_dst_we, y_mem_rd;
    drf_pkg::drf_lreg_t x_src_a, x_src_b, x_dst, y_src_a, y_src_b, y_dst;
    drf_pkg::drf_word_t mem_data, res, x_result, x_mem_addr, y_mem_addr, wb_x_data, wb_y_data;
    logic x_store_issue, wb_x_we, wb_y_we, rel_x_valid, rel_y_valid, pipe_adv, x_result_valid;
    drf_pkg::drf_preg_t wb_x_tag, wb_y_tag, rel_x_tag, rel_y_tag, x_pdst, y_pdst, x_pold, y_pold;
    logic [3:0] lat;
    logic disp_ready, ex_valid, y_hold, y_store_allow;
    drf_pkg::drf_word_t x_op_a, x_op_b, x_mem_op, y_op_a, y_op_b, y_mem_op;
    int fail_count = 0;
    int checked = 0;
    int cycles = 0;
    localparam drf_pkg::drf_word_t MD = 32'h5a5a0f0f;

    drf_rename_fwd drf_rename_fwd_i (.*);
    drf_exec_model drf_exec_model_i (.*);

    always #12.5 clk = ~clk;

    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 2000)
        begin
            fail_count++;
            finish_test();
        end
    end

    task automatic finish_test();
        $display("checked %0d mismatches %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    task automatic drive(input logic [3:0] xf, input logic [2:0] yf,
        input drf_pkg::drf_lreg_t xd, xa, xb, yd, ya, yb);
        {x_dst_we, x_mem_rd, x_mem_wr, x_is_move} = xf;
        {y_valid, y_dst_we, y_mem_rd} = yf;
        {x_dst, x_src_a, x_src_b, y_dst, y_src_a, y_src_b} = {xd, xa, xb, yd, ya, yb};
    endtask

    task automatic pair(input logic [3:0] xf, input logic [2:0] yf,
        input drf_pkg::drf_lreg_t xd, xa, xb, yd, ya, yb);
        int n;
        @(negedge clk);
        drive(xf, yf, xd, xa, xb, yd, ya, yb);
        disp_valid = 1'b1;
        n = 0;
        #1;
        while (disp_ready !== 1'b1 && n < 20)
        begin
            @(negedge clk);
            #1;
            n++;
        end
        @(negedge clk);
        disp_valid = 1'b0;
        mem_data = MD;
        @(negedge clk);
        mem_data = ~MD;
        `CHK("ex_valid", 1'b1, ex_valid)
    endtask

    task automatic t_war();
        pair(4'b1000, 3'b110, 3'h1, 3'h0, 3'h0, 3'h0, 3'h0, 3'h2);
        `CHK("x_pdst", 5'h08, x_pdst)
        `CHK("y_pdst", 5'h09, y_pdst)
        `CHK("x_pold", 5'h01, x_pold)
        `CHK("y_pold", 5'h00, y_pold)
        `CHK("x_op_a", 32'h00000011, x_op_a)
        `CHK("x_op_b", 32'h00000011, x_op_b)
        `CHK("y_op_a", 32'h00000011, y_op_a)
        `CHK("y_op_b", 32'h00000033, y_op_b)
        $display("war test done");
    endtask

    task automatic t_waw();
        pair(4'b1101, 3'b111, 3'h0, 3'h0, 3'h0, 3'h0, 3'h0, 3'h2);
        `CHK("x_pdst", 5'h0a, x_pdst)
        `CHK("y_pdst", 5'h0b, y_pdst)
        `CHK("y_pold", 5'h0a, y_pold)
        `CHK("y_op_a", MD, y_op_a)
        `CHK("x_mem_op", MD, x_mem_op)
        `CHK("y_mem_op", MD, y_mem_op)
        `CHK("y_op_b", 32'h00000033, y_op_b)
        $display("waw test done");
    endtask

    task automatic t_result();
        int n;
        lat = 4'h2;
        res = 32'hc3c3a5a5;
        pair(4'b1000, 3'b100, 3'h0, 3'h0, 3'h1, 3'h0, 3'h0, 3'h0);
        `CHK("x_pold", 5'h0b, x_pold)
        `CHK("y_hold", 1'b1, y_hold)
        n = 0;
        while (y_hold === 1'b1 && n < 10)
        begin
            @(negedge clk);
            n++;
        end
        `CHK("hold cycles", 2, n)
        `CHK("y_op_a", res, y_op_a)
        $display("result test done");
    endtask

    task automatic t_bypass();
        int n;
        lat = 4'h3;
        res = 32'h0badf00d;
        pair(4'b0010, 3'b111, 3'h0, 3'h0, 3'h0, 3'h1, 3'h1, 3'h1);
        `CHK("y_pdst", 5'h0d, y_pdst)
        `CHK("store allow", 1'b0, y_store_allow)
        x_store_issue = 1'b1;
        @(negedge clk);
        x_store_issue = 1'b0;
        `CHK("store allow", 1'b1, y_store_allow)
        n = 1;
        while (y_hold === 1'b1 && n < 10)
        begin
            @(negedge clk);
            n++;
        end
        `CHK("hold cycles", 3, n)
        `CHK("y_mem_op", res, y_mem_op)
        $display("bypass test done");
    endtask

    task automatic t_free();
        int n;
        lat = 4'h0;
        @(negedge clk);
        resetn = 1'b0;
        @(negedge clk);
        resetn = 1'b1;
        drive(4'b1000, 3'b110, 3'h3, 3'h0, 3'h0, 3'h4, 3'h0, 3'h0);
        disp_valid = 1'b1;
        n = 0;
        repeat (16)
        begin
            #1;
            if (disp_ready === 1'b1)
                n++;
            @(negedge clk);
        end
        disp_valid = 1'b0;
        `CHK("pairs taken", 12, n)
        {rel_x_valid, rel_x_tag, rel_y_valid, rel_y_tag} = {1'b1, 5'h08, 1'b1, 5'h09};
        @(negedge clk);
        {rel_x_valid, rel_y_valid} = 2'b00;
        pair(4'b1000, 3'b110, 3'h3, 3'h0, 3'h0, 3'h4, 3'h0, 3'h0);
        `CHK("x_pdst", 5'h08, x_pdst)
        `CHK("y_pdst", 5'h09, y_pdst)
        $display("free list test done");
    endtask

    initial
    begin
        {disp_valid, x_store_issue, rel_x_valid, rel_y_valid} = 4'h0;
        drive(4'h0, 3'h0, 3'h0, 3'h0, 3'h0, 3'h0, 3'h0, 3'h0);
        {mem_data, res, wb_x_data, wb_y_data} = 128'h0;
        {wb_x_we, wb_y_we, wb_x_tag, wb_y_tag, rel_x_tag, rel_y_tag} = 22'h0;
        x_mem_addr = 32'h00001000;
        y_mem_addr = 32'h00001000;
        lat = 4'h0;
        repeat (20) @(negedge clk);
        resetn = 1'b1;
        #1;
        `CHK("disp_ready", 1'b1, disp_ready)
        `CHK("store allow", 1'b0, y_store_allow)
        @(negedge clk);
        {wb_x_we, wb_x_tag, wb_x_data} = {1'b1, 5'h00, 32'h00000011};
        {wb_y_we, wb_y_tag, wb_y_data} = {1'b1, 5'h02, 32'h00000033};
        @(negedge clk);
        {wb_x_tag, wb_x_data, wb_y_we} = {5'h01, 32'h00000022, 1'b0};
        @(negedge clk);
        wb_x_we = 1'b0;
        t_war();
        t_waw();
        t_result();
        t_bypass();
        t_free();
        finish_test();
    end
endmodule
`default_nettype wire
